// File: stsc_pkg.sv
// Constants shared by the status, trigger and self-test control block.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
package stsc_pkg;

  // Register byte offsets.
  localparam logic [5:0] OFF_CMD = 6'h00;
  localparam logic [5:0] OFF_CTRL = 6'h04;
  localparam logic [5:0] OFF_SRE = 6'h08;
  localparam logic [5:0] OFF_STB = 6'h0c;
  localparam logic [5:0] OFF_SPOLL = 6'h10;
  localparam logic [5:0] OFF_OPER = 6'h14;
  localparam logic [5:0] OFF_TVOLT = 6'h18;
  localparam logic [5:0] OFF_TCURR = 6'h1c;
  localparam logic [5:0] OFF_VOLT = 6'h20;
  localparam logic [5:0] OFF_CURR = 6'h24;
  localparam logic [5:0] OFF_TEST = 6'h28;
  localparam logic [5:0] OFF_BUSY = 6'h2c;

  // Command register bits; each written one fires its command once.
  localparam int CMD_TRG = 0;
  localparam int CMD_INIT = 1;
  localparam int CMD_ABORT = 2;
  localparam int CMD_TST = 3;
  localparam int CMD_DIAG = 4;
  localparam int CMD_WAI = 5;

  // Control register fields and reset value.
  localparam int CTRL_CONT = 0;
  localparam int CTRL_SRC_LO = 1;
  localparam int CTRL_OUT = 3;
  localparam int CTRL_SYNC = 4;
  localparam logic [1:0] SRC_BUS = 2'h1;
  localparam logic [1:0] SRC_RESET = 2'h1;

  // Status byte and operation condition layout.
  localparam int STB_SUMMARY_BIT = 6;
  localparam logic [7:0] SRE_WRITABLE = 8'hbf;
  localparam logic [7:0] SRE_RESET = 8'h00;
  localparam int OPER_WAIT_BIT = 5;

  // Self-test weights allowed in each result.
  localparam logic [7:0] TST_COMMON_MASK = 8'h17;
  localparam logic [7:0] TST_EXT_MASK = 8'hf7;
  localparam logic [2:0] TST_LAST_IDX = 3'h7;

  // Busy register bits and setpoint width.
  localparam int BUSY_TST = 0;
  localparam int BUSY_SETTLE = 1;
  localparam int SP_W = 16;
  localparam logic [SP_W-1:0] SP_RESET = 16'h0000;

  typedef enum logic [0:0] {STSC_TST_IDLE, STSC_TST_RUN} stsc_tst_t;

endpackage

// File: stsc_ctrl.sv
// Status byte, bus trigger, self-test and wait-to-continue control block.
// Assumes a single AHB-Lite master on hclk; all other inputs come from
// logic on the same clock, so none of them is synchronised here.
//
// Overview of operation
// RULE1: Status byte query returns 0..255 and leaves every bit unchanged.
// RULE2: Bit six carries the master summary when any enabled condition requests service.
// RULE3: Serial poll returns bit six as request flag and clears that flag.
// RULE4: Status byte clears only through its sources; a query never clears it.
// RULE5: Bus trigger fires only with source bus and waiting flag set.
// RULE6: Continuous arming keeps the trigger armed for every later bus trigger.
// RULE7: Single-arm command arms exactly one later bus trigger when continuous is off.
// RULE8: Bus trigger while disarmed does nothing and raises no error.
// RULE9: Firing loads trigger voltage and current setpoints and clears the waiting flag.
// RULE10: With continuous arming on, firing rearms and sets the waiting flag again.
// RULE11: Bus trigger acts only while the device is addressed as listener.
// RULE12: Bus trigger is ignored while the output is off.
// RULE13: Self-test returns zero on pass, else a nonzero failure code.
// RULE14: Self-test runs every subtest and flags each failing one.
// RULE15: Weights: program memory 1, working memory 2, nonvolatile 4, analog link 16.
// RULE16: Weights 32, 64, 128 appear only in the extended diagnostic result.
// RULE17: Wait-to-continue holds later commands until earlier operations complete.
// RULE18: With sync measurement, wait-to-continue also waits for valid new setpoint.
// RULE19: Bit six is the OR of status bits ANDed with the enable mask.
// RULE20: Abort disarms a single-shot arm; with continuous arming it does nothing.
// RULE21: Bus trigger with another source selected does nothing at all.
//
// Local design decisions: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps

module stsc_ctrl (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [7:0] status_sources,
  input wire logic listener_addressed,
  input wire logic [7:0] subtest_fail,
  input wire logic setpoint_valid,
  output logic [stsc_pkg::SP_W-1:0] volt_setpoint,
  output logic [stsc_pkg::SP_W-1:0] curr_setpoint,
  output logic trigger_pulse,
  output logic service_request,
  output logic waiting_for_trigger_flag
);

  typedef struct packed {
    logic dp_wr;
    logic [5:0] dp_addr;
    logic [31:0] rdata;
    logic arm_cont;
    logic [1:0] src;
    logic out_on;
    logic sync;
    logic [7:0] sre;
    logic rqs;
    logic mss_d;
    logic armed;
    logic [stsc_pkg::SP_W-1:0] trig_v;
    logic [stsc_pkg::SP_W-1:0] trig_i;
    logic [stsc_pkg::SP_W-1:0] act_v;
    logic [stsc_pkg::SP_W-1:0] act_i;
    logic settle;
    stsc_pkg::stsc_tst_t tst_state;
    logic [2:0] tst_idx;
    logic tst_ext;
    logic [7:0] tst_acc;
    logic [7:0] tst_res;
    logic fire;
  } stsc_state_t;

  stsc_state_t state_reg;
  stsc_state_t state_next;

  logic [7:0] stb_base;
  logic [7:0] stb_enabled;
  logic mss;
  logic busy;
  logic stall;
  logic addr_acc;
  logic fire_ok;
  logic hsize_unused;

  // True when the address sits in the block and matches the given offset.
  function automatic logic reg_hit(input logic [31:0] addr, input logic [5:0] off);
    reg_hit = (addr[31:6] == 26'h0000000) && (addr[5:2] == off[5:2]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Status byte summary.

  // Bit six of the raw byte is never a source; the summary replaces it.
  assign stb_base = {status_sources[7], 1'b0, status_sources[5:0]};

  // Each status bit is gated by its enable bit.
  generate
    for (genvar i = 0; i < 8; i++) begin : g_mask
      assign stb_enabled[i] = stb_base[i] & state_reg.sre[i]; // RULE19
    end
  endgenerate

  // Any enabled bit raises the summary.
  assign mss = |stb_enabled; // RULE2

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake and pending-operation tracking.

  // Pending work: a running self-test or a setpoint not yet settled.
  assign busy = (state_reg.tst_state == stsc_pkg::STSC_TST_RUN) || state_reg.settle;

  // A wait-to-continue write holds its data phase, blocking the bus, while busy.
  assign stall = state_reg.dp_wr && (state_reg.dp_addr == stsc_pkg::OFF_CMD)
                 && hwdata[stsc_pkg::CMD_WAI] && busy; // RULE17 RULE18

  assign addr_acc = hsel && htrans[1] && hready;
  assign hsize_unused = |hsize;

  // A bus trigger fires only when every gating condition holds.
  assign fire_ok = hwdata[stsc_pkg::CMD_TRG] && listener_addressed // RULE11
                   && state_reg.out_on // RULE12
                   && (state_reg.src == stsc_pkg::SRC_BUS) // RULE5 RULE21
                   && state_reg.armed; // RULE8

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // Data phase writes, address phase reads, trigger, self-test and settle.
  always_comb begin
    logic [7:0] acc;
    logic sp_change;
    acc = state_reg.tst_acc;
    sp_change = 1'b0;
    state_next = state_reg;
    state_next.fire = 1'b0;
    state_next.mss_d = mss;

    // Settling ends once the new setpoint is reported valid.
    if (state_reg.settle && setpoint_valid) begin
      state_next.settle = 1'b0;
    end

    // Data phase of a write; nothing executes while it is held.
    if (state_reg.dp_wr && !stall) begin
      state_next.dp_wr = 1'b0;
      unique case (state_reg.dp_addr)
        stsc_pkg::OFF_CMD: begin
          if (hwdata[stsc_pkg::CMD_ABORT] && !state_reg.arm_cont) begin
            state_next.armed = 1'b0; // RULE20
          end
          if (hwdata[stsc_pkg::CMD_INIT] && !state_reg.arm_cont) begin
            state_next.armed = 1'b1; // RULE7
          end
          if (fire_ok) begin
            state_next.fire = 1'b1;
            state_next.act_v = state_reg.trig_v; // RULE9
            state_next.act_i = state_reg.trig_i; // RULE9
            state_next.armed = state_reg.arm_cont; // RULE9 RULE10
            sp_change = 1'b1;
          end
          if ((hwdata[stsc_pkg::CMD_TST] || hwdata[stsc_pkg::CMD_DIAG])
              && (state_reg.tst_state == stsc_pkg::STSC_TST_IDLE)) begin
            state_next.tst_state = stsc_pkg::STSC_TST_RUN;
            state_next.tst_idx = 3'h0;
            state_next.tst_acc = 8'h00;
            state_next.tst_ext = hwdata[stsc_pkg::CMD_DIAG];
          end
        end
        stsc_pkg::OFF_CTRL: begin
          state_next.arm_cont = hwdata[stsc_pkg::CTRL_CONT];
          state_next.src = hwdata[stsc_pkg::CTRL_SRC_LO +: 2];
          state_next.out_on = hwdata[stsc_pkg::CTRL_OUT];
          state_next.sync = hwdata[stsc_pkg::CTRL_SYNC];
          if (hwdata[stsc_pkg::CTRL_CONT]) begin
            state_next.armed = 1'b1; // RULE6
          end
        end
        stsc_pkg::OFF_SRE: begin
          state_next.sre = hwdata[7:0] & stsc_pkg::SRE_WRITABLE;
        end
        stsc_pkg::OFF_TVOLT: begin
          state_next.trig_v = hwdata[stsc_pkg::SP_W-1:0];
        end
        stsc_pkg::OFF_TCURR: begin
          state_next.trig_i = hwdata[stsc_pkg::SP_W-1:0];
        end
        stsc_pkg::OFF_VOLT: begin
          state_next.act_v = hwdata[stsc_pkg::SP_W-1:0];
          sp_change = 1'b1;
        end
        stsc_pkg::OFF_CURR: begin
          state_next.act_i = hwdata[stsc_pkg::SP_W-1:0];
          sp_change = 1'b1;
        end
        default: begin
        end
      endcase
    end

    // A setpoint change under sync measurement must settle first.
    if (sp_change && state_reg.sync) begin
      state_next.settle = 1'b1; // RULE18
    end

    // One subtest per cycle; a failure never stops the sequence.
    if (state_reg.tst_state == stsc_pkg::STSC_TST_RUN) begin
      acc[state_reg.tst_idx] = subtest_fail[state_reg.tst_idx]; // RULE14 RULE15
      state_next.tst_acc = acc;
      state_next.tst_idx = state_reg.tst_idx + 3'h1;
      if (state_reg.tst_idx == stsc_pkg::TST_LAST_IDX) begin
        state_next.tst_state = stsc_pkg::STSC_TST_IDLE;
        state_next.tst_res = acc & (state_reg.tst_ext ? stsc_pkg::TST_EXT_MASK // RULE16
                                                      : stsc_pkg::TST_COMMON_MASK); // RULE13
      end
    end

    // Address phase: latch writes, capture read data now.
    if (addr_acc) begin
      state_next.dp_wr = hwrite && (haddr[31:6] == 26'h0000000);
      state_next.dp_addr = {haddr[5:2], 2'b00};
      state_next.rdata = 32'h00000000;
      if (!hwrite) begin
        if (reg_hit(haddr, stsc_pkg::OFF_CTRL)) begin
          state_next.rdata = {27'h0000000, state_reg.sync, state_reg.out_on,
                              state_reg.src, state_reg.arm_cont};
        end
        if (reg_hit(haddr, stsc_pkg::OFF_SRE)) begin
          state_next.rdata = {24'h000000, state_reg.sre};
        end
        if (reg_hit(haddr, stsc_pkg::OFF_STB)) begin
          state_next.rdata = {24'h000000, stb_base[7], mss, stb_base[5:0]}; // RULE1 RULE4
        end
        if (reg_hit(haddr, stsc_pkg::OFF_SPOLL)) begin
          state_next.rdata = {24'h000000, stb_base[7], state_reg.rqs, stb_base[5:0]};
          state_next.rqs = 1'b0; // RULE3
        end
        if (reg_hit(haddr, stsc_pkg::OFF_OPER)) begin
          state_next.rdata = 32'h00000000;
          state_next.rdata[stsc_pkg::OPER_WAIT_BIT] = state_reg.armed;
        end
        if (reg_hit(haddr, stsc_pkg::OFF_TVOLT)) begin
          state_next.rdata = {16'h0000, state_reg.trig_v};
        end
        if (reg_hit(haddr, stsc_pkg::OFF_TCURR)) begin
          state_next.rdata = {16'h0000, state_reg.trig_i};
        end
        if (reg_hit(haddr, stsc_pkg::OFF_VOLT)) begin
          state_next.rdata = {16'h0000, state_reg.act_v};
        end
        if (reg_hit(haddr, stsc_pkg::OFF_CURR)) begin
          state_next.rdata = {16'h0000, state_reg.act_i};
        end
        if (reg_hit(haddr, stsc_pkg::OFF_TEST)) begin
          state_next.rdata = {24'h000000, state_reg.tst_res};
        end
        if (reg_hit(haddr, stsc_pkg::OFF_BUSY)) begin
          state_next.rdata = 32'h00000000;
          state_next.rdata[stsc_pkg::BUSY_TST] = (state_reg.tst_state == stsc_pkg::STSC_TST_RUN);
          state_next.rdata[stsc_pkg::BUSY_SETTLE] = state_reg.settle;
        end
      end
    end

    // A fresh service request wins over a poll in the same cycle.
    if (mss && !state_reg.mss_d) begin
      state_next.rqs = 1'b1; // RULE3
    end
  end

  // State register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= '{dp_wr: 1'b0, dp_addr: 6'h00, rdata: 32'h00000000,
                     arm_cont: 1'b0, src: stsc_pkg::SRC_RESET, out_on: 1'b0,
                     sync: 1'b0, sre: stsc_pkg::SRE_RESET, rqs: 1'b0, mss_d: 1'b0,
                     armed: 1'b0, trig_v: stsc_pkg::SP_RESET, trig_i: stsc_pkg::SP_RESET,
                     act_v: stsc_pkg::SP_RESET, act_i: stsc_pkg::SP_RESET, settle: 1'b0,
                     tst_state: stsc_pkg::STSC_TST_IDLE, tst_idx: 3'h0, tst_ext: 1'b0,
                     tst_acc: 8'h00, tst_res: 8'h00, fire: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs.
  assign hreadyout = !stall;
  assign hresp = 1'b0;
  assign hrdata = state_reg.rdata;
  assign volt_setpoint = state_reg.act_v;
  assign curr_setpoint = state_reg.act_i;
  assign trigger_pulse = state_reg.fire;
  assign service_request = state_reg.rqs;
  assign waiting_for_trigger_flag = state_reg.armed;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // A status query returns the summary and does not touch the request flag.
  chk_stb_no_clear: assert property ( // RULE1
    (addr_acc && !hwrite && reg_hit(haddr, stsc_pkg::OFF_STB) && !(mss && !state_reg.mss_d))
    |=> (state_reg.rqs == $past(state_reg.rqs))
        && (hrdata[7:0] == {$past(stb_base[7]), $past(mss), $past(stb_base[5:0])}))
    else $error("status query changed the request flag or returned a wrong byte");

  // The summary is exactly the OR of enabled status bits.
  chk_mss_summary: assert property ( // RULE19
    (addr_acc && !hwrite && reg_hit(haddr, stsc_pkg::OFF_STB))
    |=> hrdata[stsc_pkg::STB_SUMMARY_BIT]
        == |($past(status_sources) & $past(state_reg.sre) & stsc_pkg::SRE_WRITABLE))
    else $error("summary bit is not the OR of enabled status bits");

  // The request flag only rises on a new enabled summary.
  chk_rqs_cause: assert property ( // RULE3
    (state_reg.rqs && !$past(state_reg.rqs)) |-> $past(mss) && !$past(state_reg.mss_d))
    else $error("request flag set without a new enabled summary");

  // A serial poll clears the request flag unless a new request arrives.
  chk_poll_clears: assert property ( // RULE3
    (addr_acc && !hwrite && reg_hit(haddr, stsc_pkg::OFF_SPOLL) && !(mss && !state_reg.mss_d))
    |=> !state_reg.rqs ##0 hrdata[6] == $past(state_reg.rqs))
    else $error("serial poll did not clear or report the request flag");

  // A trigger fires only under every gating condition.
  chk_trig_gate: assert property ( // RULE5
    $rose(trigger_pulse) |-> $past(state_reg.armed) && $past(state_reg.out_on)
      && $past(listener_addressed) && ($past(state_reg.src) == stsc_pkg::SRC_BUS))
    else $error("trigger fired without arm, output, listener or bus source");

  // A single-shot trigger leaves the system disarmed.
  chk_single_shot: assert property ( // RULE7
    (state_next.fire && !state_reg.arm_cont) |=> !waiting_for_trigger_flag)
    else $error("single-shot trigger left the system armed");

  // Continuous arming rearms at once.
  chk_cont_rearm: assert property ( // RULE10
    (state_next.fire && state_reg.arm_cont) |=> waiting_for_trigger_flag [*2])
    else $error("continuous arming did not stay armed after a trigger");

  // Firing loads the trigger levels.
  chk_trig_load: assert property ( // RULE9
    trigger_pulse |-> (volt_setpoint == $past(state_reg.trig_v))
                      && (curr_setpoint == $past(state_reg.trig_i)))
    else $error("trigger did not load the trigger setpoints");

  // Abort disarms a single-shot arm.
  chk_abort_disarm: assert property ( // RULE20
    (state_reg.dp_wr && !stall && state_reg.dp_addr == stsc_pkg::OFF_CMD
     && hwdata[stsc_pkg::CMD_ABORT] && !hwdata[stsc_pkg::CMD_INIT] && !state_reg.arm_cont)
    |=> !waiting_for_trigger_flag)
    else $error("abort left a single-shot trigger armed");

  // The common self-test never reports the extended weights.
  chk_common_mask: assert property ( // RULE16
    ($fell(state_reg.tst_state == stsc_pkg::STSC_TST_RUN) && !state_reg.tst_ext)
    |-> (state_reg.tst_res & ~stsc_pkg::TST_COMMON_MASK) == 8'h00)
    else $error("common self-test reported an extended failure weight");

  // A self-test ends eight cycles after it starts.
  chk_tst_length: assert property ( // RULE14
    $rose(state_reg.tst_state == stsc_pkg::STSC_TST_RUN)
    |-> (state_reg.tst_state == stsc_pkg::STSC_TST_RUN) [*8] ##1
        (state_reg.tst_state == stsc_pkg::STSC_TST_IDLE))
    else $error("self-test did not run all subtests");

  // Wait-to-continue holds the bus and its own data phase while work is pending.
  chk_wai_hold: assert property ( // RULE17
    (state_reg.dp_wr && state_reg.dp_addr == stsc_pkg::OFF_CMD && hwdata[stsc_pkg::CMD_WAI]
     && (state_reg.tst_state == stsc_pkg::STSC_TST_RUN || state_reg.settle))
    |-> !hreadyout ##1 state_reg.dp_wr)
    else $error("wait-to-continue released the bus while busy");

endmodule

// File: stsc_far.sv
// Model of the analog side that the control block steers: listener select and setpoint settling.
// Assumes the bench gives the listener request; new setpoints read invalid for DLY+1 cycles.
`timescale 1ns/1ps

module stsc_far #(
  parameter int DLY = 6
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic listen_req,
  input wire logic [15:0] volt_setpoint,
  input wire logic [15:0] curr_setpoint,
  output logic listener_addressed,
  output logic setpoint_valid
);
  logic [15:0] last_v;
  logic [15:0] last_c;
  logic [3:0] cnt;
  logic chg;

  ////////////////////////////////////////////////////////////////////////////////
  // The controller selects the device as listener only when the bench asks.
  assign listener_addressed = listen_req;
  // A changed setpoint turns valid low at once, so no stale high is seen.
  assign chg = (volt_setpoint != last_v) || (curr_setpoint != last_c);
  assign setpoint_valid = !chg && (cnt == 4'h0);

  // Settling counter restarts on every setpoint change.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_v <= 16'h0000;
      last_c <= 16'h0000;
      cnt <= 4'h0;
    end else begin
      last_v <= volt_setpoint;
      last_c <= curr_setpoint;
      if (chg) begin
        cnt <= DLY[3:0];
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule

// File: status_trigger_selftest_ctrl_bench.sv
// Self-checking bench for the status, trigger, self-test and wait control block.
// Assumes one AHB-Lite master (this bench) and the far-side model on the same clock.
`timescale 1ns/1ps

module status_trigger_selftest_ctrl_bench;
  logic hclk, hresetn, hsel, hwrite, listen;
  logic [31:0] haddr, hwdata, seen;
  logic [1:0] htrans;
  logic hreadyout, hresp, lst, tp, sr, armed_flag, spv;
  logic [31:0] hrdata;
  logic [7:0] src, fails, s, m;
  logic [15:0] vs, cs, tv, tc;
  logic [7:0] tab [4];
  logic [31:0] exp_q [$];
  int n_fail, n_tests, pulses;
  bit wait_seen;
  event rd_ev;

  stsc_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .status_sources(src), .listener_addressed(lst),
    .subtest_fail(fails), .setpoint_valid(spv), .volt_setpoint(vs), .curr_setpoint(cs),
    .trigger_pulse(tp), .service_request(sr), .waiting_for_trigger_flag(armed_flag));

  stsc_far far (.hclk(hclk), .hresetn(hresetn), .listen_req(listen), .volt_setpoint(vs),
    .curr_setpoint(cs), .listener_addressed(lst), .setpoint_valid(spv));

  ////////////////////////////////////////////////////////////////////////////////
  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [31:0] sv, input logic [31:0] ev);
    n_tests++;
    if (sv !== ev) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ev, sv);
    end
  endtask

  // One AHB-Lite single transfer; read data is taken at the closing edge.
  task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int t;
    t = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {26'h0, a};
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && t < 500) begin
      @(posedge hclk);
      t++;
    end
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && t < 500) begin
      wait_seen = 1'b1;
      @(posedge hclk);
      t++;
    end
    seen = hrdata;
    if (t >= 500) n_fail++;
  endtask

  // A read notes its expected word; the monitor compares it.
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0);
    ->rd_ev;
  endtask

  // Writes a command word, then checks pulse count and the waiting flag.
  task automatic fire(input logic [31:0] d, input int n, input logic w);
    int p0;
    p0 = pulses;
    xfer(1'b1, stsc_pkg::OFF_CMD, d);
    repeat (2) @(posedge hclk);
    chk("pulses", pulses - p0, n);
    chk("armed_flag", {31'h0, armed_flag}, {31'h0, w});
  endtask

  // Polls the busy register until nothing is pending.
  task automatic idle_wait;
    for (int t = 0; t < 50; t++) begin
      xfer(1'b0, stsc_pkg::OFF_BUSY, 32'h0);
      if (seen[1:0] === 2'b00) break;
    end
  endtask

  task automatic end_sim;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 100 MHz.
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // Monitor: every finished read takes the oldest note off the queue.
  initial begin
    forever begin
      @(rd_ev);
      chk("hrdata", seen, exp_q.pop_front());
      chk("hresp", {31'h0, hresp}, 32'h0);
    end
  end

  // Counts trigger pulses.
  always @(posedge hclk) if (tp === 1'b1) pulses++;

  // Watchdog against a hung handshake.
  initial begin
    #500000;
    n_fail++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    {hsel, hwrite, listen, htrans, haddr, hwdata, src, fails} = '0;
    hresetn = 1'b0;
    n_fail = 0;
    n_tests = 0;
    pulses = 0;
    void'($urandom(12430));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(stsc_pkg::OFF_CTRL, 32'h2);
    rd(stsc_pkg::OFF_SRE, 32'h0);
    rd(stsc_pkg::OFF_OPER, 32'h0);
    xfer(1'b1, 6'h30, 32'hffff_ffff);
    rd(6'h30, 32'h0);
    xfer(1'b1, stsc_pkg::OFF_SRE, 32'hff);
    rd(stsc_pkg::OFF_SRE, 32'hbf);
    // Status byte, summary bit and serial poll with random sources and masks.
    for (int i = 0; i < 3; i++) begin
      s = 8'(($urandom & 8'hbf) | 8'h01);
      m = 8'($urandom | 8'h01);
      src <= 8'h00;
      xfer(1'b1, stsc_pkg::OFF_SRE, {24'h0, m});
      src <= s | 8'h40;
      repeat (3) @(posedge hclk);
      rd(stsc_pkg::OFF_STB, {24'h0, s | 8'h40});
      rd(stsc_pkg::OFF_STB, {24'h0, s | 8'h40});
      chk("srq", {31'h0, sr}, 32'h1);
      rd(stsc_pkg::OFF_SPOLL, {24'h0, s | 8'h40});
      rd(stsc_pkg::OFF_SPOLL, {24'h0, s});
      @(posedge hclk);
      chk("srq", {31'h0, sr}, 32'h0);
      xfer(1'b1, stsc_pkg::OFF_SRE, {24'h0, ~s});
      rd(stsc_pkg::OFF_STB, {24'h0, s});
    end
    src <= 8'h00;
    repeat (2) @(posedge hclk);
    rd(stsc_pkg::OFF_STB, 32'h0);
    // Bus trigger arming, firing and gating.
    tv = 16'($urandom);
    tc = 16'($urandom);
    xfer(1'b1, stsc_pkg::OFF_TVOLT, {16'h0, tv});
    xfer(1'b1, stsc_pkg::OFF_TCURR, {16'h0, tc});
    listen <= 1'b1;
    xfer(1'b1, stsc_pkg::OFF_CTRL, 32'h0a);
    fire(32'h01, 0, 1'b0);
    fire(32'h02, 0, 1'b1);
    rd(stsc_pkg::OFF_OPER, 32'h20);
    listen <= 1'b0;
    fire(32'h01, 0, 1'b1);
    listen <= 1'b1;
    fire(32'h01, 1, 1'b0);
    chk("volt", {16'h0, vs}, {16'h0, tv});
    chk("curr", {16'h0, cs}, {16'h0, tc});
    fire(32'h01, 0, 1'b0);
    fire(32'h02, 0, 1'b1);
    fire(32'h04, 0, 1'b0);
    fire(32'h01, 0, 1'b0);
    xfer(1'b1, stsc_pkg::OFF_CTRL, 32'h0c);
    fire(32'h02, 0, 1'b1);
    fire(32'h01, 0, 1'b1);
    xfer(1'b1, stsc_pkg::OFF_CTRL, 32'h02);
    fire(32'h01, 0, 1'b1);
    xfer(1'b1, stsc_pkg::OFF_CTRL, 32'h0b);
    fire(32'h01, 1, 1'b1);
    fire(32'h01, 1, 1'b1);
    fire(32'h04, 0, 1'b1);
    xfer(1'b1, stsc_pkg::OFF_CTRL, 32'h0a);
    // Self-test and extended diagnostic results.
    tab = '{8'h00, 8'hff, 8'h08, 8'h00};
    tab[3] = 8'($urandom);
    foreach (tab[i]) begin
      fails <= tab[i];
      xfer(1'b1, stsc_pkg::OFF_CMD, 32'h08);
      idle_wait();
      rd(stsc_pkg::OFF_TEST, {24'h0, tab[i] & 8'h17});
      xfer(1'b1, stsc_pkg::OFF_CMD, 32'h10);
      idle_wait();
      rd(stsc_pkg::OFF_TEST, {24'h0, tab[i] & 8'hf7});
    end
    // Wait-to-continue behind a running self-test, then behind settling.
    fails <= 8'h12;
    xfer(1'b1, stsc_pkg::OFF_CMD, 32'h08);
    wait_seen = 1'b0;
    xfer(1'b1, stsc_pkg::OFF_CMD, 32'h20);
    chk("wai_hold", {31'h0, wait_seen}, 32'h1);
    rd(stsc_pkg::OFF_BUSY, 32'h0);
    rd(stsc_pkg::OFF_TEST, 32'h12);
    xfer(1'b1, stsc_pkg::OFF_CTRL, 32'h1a);
    xfer(1'b1, stsc_pkg::OFF_VOLT, {16'h0, ~tv});
    xfer(1'b1, stsc_pkg::OFF_CURR, {16'h0, ~tc});
    wait_seen = 1'b0;
    xfer(1'b1, stsc_pkg::OFF_CMD, 32'h20);
    chk("wai_settle", {31'h0, wait_seen}, 32'h1);
    chk("valid", {31'h0, spv}, 32'h1);
    chk("volt", {16'h0, vs}, {16'h0, ~tv});
    chk("curr", {16'h0, cs}, {16'h0, ~tc});
    rd(stsc_pkg::OFF_CURR, {16'h0, ~tc});
    rd(stsc_pkg::OFF_TVOLT, {16'h0, tv});
    rd(stsc_pkg::OFF_BUSY, 32'h0);
    repeat (2) @(posedge hclk);
    end_sim();
  end
endmodule
